//--- dcf_pkg.sv
// Shared constants of the dual clock FIFO flag block
//=============================================================
// Functional notes
// RULE1: Write strobe low stores word each write edge
// RULE2: Output-ready falls when first word reaches outputs
// RULE3: Almost-empty rises at empty offset plus two
// RULE4: Half-full falls at 4098 or 8194 words
// RULE5: Almost-full falls at capacity minus full offset
// RULE6: Input-ready rises when full, writes blocked
// RULE7: First read from full drops input-ready
// RULE8: Almost-empty falls at empty offset plus one
// RULE9: Empty: output-ready high, read strobe ignored
// RULE10: Output-ready three stages, input-ready two stages
// RULE11: Load high at reset: serial, offsets 3FF
// RULE12: Load low at reset selects parallel loading
// RULE13: Parallel loading presets both offsets to 07F
// RULE14: Offsets read back only by parallel read
// RULE15: Offsets reprogrammable any time after reset
// RULE16: Standard mode almost-full and full thresholds
// RULE17: Default empty offset 127 or 1023
// RULE18: Timing mode latched from select pin at reset
// RULE19: First word falls through after three read edges
// RULE20: Parallel writes alternate empty, full, empty offsets
// RULE21: Serial shift 26 or 28 bits, LSB first
//=============================================================
package dcf_pkg;
    //=========================================================
    // Geometry
    localparam int DATA_W = 18;
    localparam int DEPTH_DEF = 8192;
    //=========================================================
    // Offset presets
    localparam logic [15:0] OFS_SERIAL_DEF   = 16'h03FF;
    localparam logic [15:0] OFS_PARALLEL_DEF = 16'h007F;
    //=========================================================
    // Flag pipeline lengths, in edges of the owning clock
    localparam int FETCH_EDGES = 3;
    localparam int IR_STAGES   = 2;
    localparam int STD_STAGES  = 2;
endpackage

//--- dcf_pin_sync.sv
// Three stage pin synchroniser with agreement filter
module dcf_pin_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         mclk,
    input  wire logic         rst,
    // Pins
    input  wire logic [W-1:0] pin_in,
    output logic      [W-1:0] pin_out
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] clean;
    } dcf_sync_s;

    dcf_sync_s r;
    dcf_sync_s next_r;

    //=========================================================
    // Stages
    always_comb begin
        next_r       = r;
        next_r.s1    = pin_in;
        next_r.s2    = r.s1;
        next_r.s3    = r.s2;
        // A change counts only once stages two and three agree
        next_r.clean = (r.s2 & ~(r.s2 ^ r.s3)) | (r.clean & (r.s2 ^ r.s3));
    end

    // Idle level high suits the active-low strobes
    always_ff @(posedge mclk) begin
        if (rst) begin
            r <= '1;
        end else begin
            r <= next_r;
        end
    end

    assign pin_out = r.clean;
endmodule // dcf_pin_sync

//--- dcf_mem.sv
// FIFO storage array, one write port and one read port
module dcf_mem #(
    parameter int DW    = 18,
    parameter int DEPTH = 8192,
    parameter int AW    = $clog2(DEPTH)
) (
    // Clock
    input  wire logic          mclk,
    // Write port
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [DW-1:0] wdata,
    // Read port
    input  wire logic [AW-1:0] raddr,
    output logic      [DW-1:0] rdata
);
    logic [DW-1:0] mem [DEPTH];

    //=========================================================
    // Storage, no reset: contents are undefined until written
    always_ff @(posedge mclk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    assign rdata = mem[raddr];
endmodule // dcf_mem

//--- dcf_fifo_flags.sv
// Dual clock FIFO with status flags and offset programming
//
// Implementation choices: every pin sampled on mclk through synchronisers, and the flag pipelines.
module dcf_fifo_flags
    import dcf_pkg::*;
#(
    parameter int DEPTH = dcf_pkg::DEPTH_DEF
) (
    // System clock and reset
    input  wire logic                      mclk,
    input  wire logic                      rst,
    // Master reset and strap pins
    input  wire logic                      master_reset_n,
    input  wire logic                      fallthrough_sel_serial_in,
    input  wire logic                      offset_load_n,
    // Writer pins
    input  wire logic                      wclk,
    input  wire logic                      write_en_n,
    input  wire logic                      serial_shift_enable_n,
    input  wire logic [dcf_pkg::DATA_W-1:0] write_data_bus,
    // Reader pins
    input  wire logic                      rclk,
    input  wire logic                      read_en_n,
    output logic      [dcf_pkg::DATA_W-1:0] read_data_bus,
    // Status flags
    output logic                           full_flag_n,
    output logic                           input_ready_n,
    output logic                           empty_flag_n,
    output logic                           output_ready_n,
    output logic                           almost_full_n,
    output logic                           almost_empty_n,
    output logic                           half_full_n
);
    localparam int AW    = $clog2(DEPTH);
    localparam int OFS_W = AW;
    localparam int CW    = $clog2(DEPTH + 1);
    localparam int SW    = 2 * OFS_W;
    localparam int SCW   = $clog2(SW + 1);
    localparam int PW    = 10;

    localparam logic [CW:0]    DEP     = (CW+1)'(DEPTH);
    localparam logic [CW:0]    HALF    = (CW+1)'(DEPTH / 2 + 1);
    localparam logic [SCW-1:0] SER_LEN = SCW'(SW);
    localparam logic [OFS_W-1:0] SER_DEF = OFS_W'(OFS_SERIAL_DEF);
    localparam logic [OFS_W-1:0] PAR_DEF = OFS_W'(OFS_PARALLEL_DEF);
    localparam logic [1:0] FETCH_LAST = 2'(FETCH_EDGES - 1);

    typedef struct packed {
        logic              fall_through_mode;
        logic              serial;
        logic [OFS_W-1:0]  ofs_empty;
        logic [OFS_W-1:0]  ofs_full;
        logic [SW-1:0]     shreg;
        logic [SCW-1:0]    shcnt;
        logic              pwr_sel;
        logic              prd_sel;
        logic [AW-1:0]     wp;
        logic [AW-1:0]     rp;
        logic [CW-1:0]     mcnt;
        logic              out_valid;
        logic [1:0]        fetch;
        logic              wclk_d;
        logic              rclk_d;
        logic [IR_STAGES-1:0]  ir_pipe;
        logic [STD_STAGES-1:0] ff_pipe;
        logic [STD_STAGES-1:0] ef_pipe;
        logic [DATA_W-1:0] q;
        logic              o_ff_n;
        logic              o_ir_n;
        logic              o_ef_n;
        logic              o_or_n;
        logic              o_paf_n;
        logic              o_pae_n;
        logic              o_hf_n;
    } dcf_state_s;

    dcf_state_s r;
    dcf_state_s next_r;

    //=========================================================
    // Pin synchronisers
    logic [PW-1:0]     pins_raw;
    logic [PW-1:0]     pins;
    logic [DATA_W-1:0] wdata_s;
    logic              s_mrs_n;
    logic              s_fallthrough_sel_serial_in;
    logic              s_ld_n;
    logic              s_wclk;
    logic              s_wen_n;
    logic              s_sen_n;
    logic              s_rclk;
    logic              s_ren_n;

    assign pins_raw = {master_reset_n, fallthrough_sel_serial_in,
                       offset_load_n, wclk, write_en_n,
                       serial_shift_enable_n, rclk, read_en_n, 2'b11};
    assign {s_mrs_n, s_fallthrough_sel_serial_in, s_ld_n, s_wclk, s_wen_n,
            s_sen_n, s_rclk, s_ren_n} = pins[PW-1:2];

    // Data rides the same pipeline depth as the write clock pin
    dcf_pin_sync #(.W(PW)) u_ctl_sync (
        .mclk    (mclk),
        .rst     (rst),
        .pin_in  (pins_raw),
        .pin_out (pins)
    );

    dcf_pin_sync #(.W(DATA_W)) u_dat_sync (
        .mclk    (mclk),
        .rst     (rst),
        .pin_in  (write_data_bus),
        .pin_out (wdata_s)
    );

    //=========================================================
    // Storage
    logic              mem_we;
    logic [DATA_W-1:0] mem_rdata;

    dcf_mem #(.DW(DATA_W), .DEPTH(DEPTH)) u_mem (
        .mclk  (mclk),
        .we    (mem_we),
        .waddr (r.wp),
        .wdata (wdata_s),
        .raddr (r.rp),
        .rdata (mem_rdata)
    );

    //=========================================================
    // Helpers
    function automatic logic [CW:0] thr(input logic [CW:0] base,
                                        input logic        f);
        return base + {{CW{1'b0}}, f};
    endfunction

    function automatic logic [CW:0] ext(input logic [OFS_W-1:0] v);
        return {{(CW+1-OFS_W){1'b0}}, v};
    endfunction

    //=========================================================
    // Next state
    logic          wedge;
    logic          redge;
    logic          full;
    logic          wr_mem;
    logic          pop;
    logic [CW:0]   tot;
    logic [SW-1:0] sh_next;

    assign mem_we = wr_mem;

    always_comb begin
        next_r  = r;
        wedge   = s_wclk & ~r.wclk_d;
        redge   = s_rclk & ~r.rclk_d;
        wr_mem  = 1'b0;
        pop     = 1'b0;
        sh_next = {s_fallthrough_sel_serial_in, r.shreg[SW-1:1]};
        tot     = {1'b0, r.mcnt} + {{CW{1'b0}}, r.out_valid & r.fall_through_mode};
        // Memory itself may be full while the output word is in flight
        full    = (tot >= thr(DEP, r.fall_through_mode)) || (r.mcnt == DEP[CW-1:0]);
        next_r.wclk_d = s_wclk;
        next_r.rclk_d = s_rclk;

        //-----------------------------------------------------
        // Write side
        if (wedge) begin
            if (s_ld_n && !s_wen_n && !full) begin
                wr_mem    = 1'b1;                        // [RULE1] [RULE6]
                next_r.wp = r.wp + 1'b1;
            end else if (!s_ld_n && !s_wen_n && !r.serial) begin
                if (r.pwr_sel) begin                     // [RULE20] [RULE15]
                    next_r.ofs_full = wdata_s[OFS_W-1:0];
                end else begin
                    next_r.ofs_empty = wdata_s[OFS_W-1:0];
                end
                next_r.pwr_sel = ~r.pwr_sel;
            end else if (!s_ld_n && !s_sen_n && s_wen_n && r.serial) begin
                // Offsets change only once the whole set has arrived
                next_r.shreg = sh_next;                  // [RULE21]
                if (r.shcnt == SER_LEN - 1'b1) begin
                    next_r.shcnt     = '0;
                    next_r.ofs_empty = sh_next[OFS_W-1:0];
                    next_r.ofs_full  = sh_next[SW-1:OFS_W];
                end else begin
                    next_r.shcnt = r.shcnt + 1'b1;
                end
            end
            next_r.ir_pipe = {r.ir_pipe[IR_STAGES-2:0], full};     // [RULE10]
            next_r.ff_pipe = {r.ff_pipe[STD_STAGES-2:0], ~full};
        end

        //-----------------------------------------------------
        // Read side
        if (redge) begin
            next_r.ef_pipe = {r.ef_pipe[STD_STAGES-2:0], r.mcnt != '0};
            if (!s_ld_n && !s_ren_n) begin
                // Offset readback works in either loading method
                next_r.q = r.prd_sel ? DATA_W'(r.ofs_full)   // [RULE14]
                                     : DATA_W'(r.ofs_empty);
                next_r.prd_sel = ~r.prd_sel;
            end else if (r.fall_through_mode) begin
                if (s_ld_n && !s_ren_n && r.out_valid) begin
                    if (r.mcnt != '0) begin
                        pop      = 1'b1;
                        next_r.q = mem_rdata;
                    end else begin
                        next_r.out_valid = 1'b0;         // [RULE9]
                        next_r.fetch     = '0;
                    end
                end else if (!r.out_valid && r.mcnt != '0) begin
                    // Third read edge loads the word, no strobe needed
                    if (r.fetch == FETCH_LAST) begin     // [RULE19] [RULE10]
                        pop              = 1'b1;
                        next_r.q         = mem_rdata;
                        next_r.out_valid = 1'b1;
                        next_r.fetch     = '0;
                    end else begin
                        next_r.fetch = r.fetch + 1'b1;
                    end
                end
            end else if (s_ld_n && !s_ren_n && r.mcnt != '0) begin
                pop      = 1'b1;
                next_r.q = mem_rdata;
            end
        end
        if (pop) begin
            next_r.rp = r.rp + 1'b1;
        end
        next_r.mcnt = CW'({1'b0, r.mcnt} + {{CW{1'b0}}, wr_mem}
                          - {{CW{1'b0}}, pop});

        //-----------------------------------------------------
        // Flags
        next_r.o_pae_n = tot > thr(ext(r.ofs_empty), r.fall_through_mode); // [RULE3] [RULE8]
        next_r.o_hf_n  = !(tot >= thr(HALF, r.fall_through_mode));          // [RULE4]
        next_r.o_paf_n = !(tot >= thr(DEP - ext(r.ofs_full),
                                      r.fall_through_mode));        // [RULE5] [RULE7] [RULE16]
        next_r.o_ir_n  = r.fall_through_mode ? r.ir_pipe[IR_STAGES-1] : 1'b1; // [RULE6] [RULE7]
        next_r.o_or_n  = r.fall_through_mode ? ~r.out_valid : 1'b1;   // [RULE2] [RULE9]
        next_r.o_ff_n  = r.fall_through_mode ? 1'b1 : r.ff_pipe[STD_STAGES-1]; // [RULE16]
        next_r.o_ef_n  = r.fall_through_mode ? 1'b1 : r.ef_pipe[STD_STAGES-1];

        //-----------------------------------------------------
        // Master reset pin: straps caught while it is held
        if (!s_mrs_n) begin
            next_r.fall_through_mode      = s_fallthrough_sel_serial_in;                // [RULE18]
            next_r.serial    = s_ld_n;                   // [RULE11] [RULE12]
            next_r.ofs_empty = s_ld_n ? SER_DEF : PAR_DEF; // [RULE13] [RULE17]
            next_r.ofs_full  = s_ld_n ? SER_DEF : PAR_DEF;
            next_r.shcnt     = '0;
            next_r.pwr_sel   = 1'b0;
            next_r.prd_sel   = 1'b0;
            next_r.wp        = '0;
            next_r.rp        = '0;
            next_r.mcnt      = '0;
            next_r.out_valid = 1'b0;
            next_r.fetch     = '0;
            next_r.q         = '0;
        end
    end

    //=========================================================
    // State register
    always_ff @(posedge mclk) begin
        if (rst) begin
            r           <= '0;
            r.ofs_empty <= PAR_DEF;
            r.ofs_full  <= PAR_DEF;
            r.wclk_d    <= 1'b1;
            r.rclk_d    <= 1'b1;
            r.ff_pipe   <= '1;
            r.o_ff_n    <= 1'b1;
            r.o_ir_n    <= 1'b1;
            r.o_or_n    <= 1'b1;
            r.o_paf_n   <= 1'b1;
            r.o_hf_n    <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    //=========================================================
    // Outputs
    assign read_data_bus  = r.q;
    assign full_flag_n    = r.o_ff_n;
    assign input_ready_n  = r.o_ir_n;
    assign empty_flag_n   = r.o_ef_n;
    assign output_ready_n = r.o_or_n;
    assign almost_full_n  = r.o_paf_n;
    assign almost_empty_n = r.o_pae_n;
    assign half_full_n    = r.o_hf_n;
endmodule // dcf_fifo_flags

//--- dcf_fifo_flags_assertions.sv
// Checker of flag consistency at the FIFO flag block ports
module dcf_fifo_flags_chk
    import dcf_pkg::*;
(
    // Clock, resets and offset load pin
    input wire logic                       mclk,
    input wire logic                       rst,
    input wire logic                       master_reset_n,
    input wire logic                       offset_load_n,
    // Watched outputs
    input wire logic [dcf_pkg::DATA_W-1:0] read_data_bus,
    input wire logic                       full_flag_n,
    input wire logic                       input_ready_n,
    input wire logic                       empty_flag_n,
    input wire logic                       output_ready_n,
    input wire logic                       almost_full_n,
    input wire logic                       almost_empty_n,
    input wire logic                       half_full_n
);
    import dcf_pkg::*;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    //=========================================================
    // Flag relations
    chk_mr_clears: assert property (
        !master_reset_n [*8] |-> read_data_bus == '0 && output_ready_n
        && !almost_empty_n) else $error("master reset did not clear");
    chk_full_std: assert property (
        !full_flag_n |-> !almost_full_n && !half_full_n && empty_flag_n)
        else $error("full flag without full levels");
    chk_empty_std: assert property (
        !empty_flag_n |-> !almost_empty_n && half_full_n && full_flag_n
        && output_ready_n) else $error("empty flag inconsistent");
    chk_full_ft: assert property (
        input_ready_n && !output_ready_n |-> !almost_full_n
        && !half_full_n && almost_empty_n) else $error("input ready bad");
    chk_af_hf: assert property (
        almost_empty_n && !almost_full_n |-> !half_full_n)
        else $error("almost full before half full");
    chk_ir_rise: assert property (
        master_reset_n && $rose(input_ready_n)
        |-> !output_ready_n && full_flag_n)
        else $error("input ready rose while empty");
    chk_or_fall: assert property (
        $fell(output_ready_n) |-> empty_flag_n && full_flag_n)
        else $error("output ready fell in standard mode");
    chk_or_hold: assert property (
        output_ready_n && $stable(output_ready_n) && empty_flag_n
        && !input_ready_n && offset_load_n && master_reset_n
        |=> $stable(read_data_bus) or ##1 !output_ready_n)
        else $error("data moved while empty");
endmodule // dcf_fifo_flags_chk

bind dcf_fifo_flags dcf_fifo_flags_chk dcf_fifo_flags_chk_i (
    .mclk(mclk), .rst(rst), .master_reset_n(master_reset_n),
    .offset_load_n(offset_load_n),
    .read_data_bus(read_data_bus), .full_flag_n(full_flag_n),
    .input_ready_n(input_ready_n), .empty_flag_n(empty_flag_n),
    .output_ready_n(output_ready_n), .almost_full_n(almost_full_n),
    .almost_empty_n(almost_empty_n), .half_full_n(half_full_n));

//--- dcf_pins_model.sv
// Writer and reader pin model with free running pin clocks
module dcf_pins_model
    import dcf_pkg::*;
(
    // System clock
    input wire logic                  mclk,
    // Strap and control pins
    output logic                      master_reset_n,
    output logic                      fallthrough_sel_serial_in,
    output logic                      offset_load_n,
    output logic                      serial_shift_enable_n,
    // Writer and reader pins
    output logic                      wclk,
    output logic                      write_en_n,
    output logic [dcf_pkg::DATA_W-1:0] write_data_bus,
    output logic                      rclk,
    output logic                      read_en_n
);
    import dcf_pkg::*;
    int wc = 0;
    int rc = 0;
    initial begin
        {master_reset_n, offset_load_n, write_en_n, read_en_n} = 4'hF;
        {fallthrough_sel_serial_in, wclk, rclk} = 3'h0;
        serial_shift_enable_n = 1'b1;
        write_data_bus = '0;
    end
    //=========================================================
    // Unrelated pin clocks, phases kept well above sync needs
    always @(posedge mclk) begin
        wc <= (wc == 4) ? 0 : wc + 1;
        rc <= (rc == 6) ? 0 : rc + 1;
        if (wc == 4) wclk <= ~wclk;
        if (rc == 6) rclk <= ~rclk;
    end
    //=========================================================
    // One strobed pin cycle; strobe held past the synced edge
    task automatic op(input bit rd, input bit ld,
                      input logic [DATA_W-1:0] d);
        if (rd) @(negedge rclk);
        else @(negedge wclk);
        @(posedge mclk);
        offset_load_n <= ~ld;
        write_data_bus <= d;
        if (rd) read_en_n <= 1'b0;
        else write_en_n <= 1'b0;
        if (rd) @(posedge rclk);
        else @(posedge wclk);
        repeat (5) @(posedge mclk);
        {read_en_n, write_en_n, offset_load_n} <= 3'h7;
        write_data_bus <= ~d;
    endtask
    // One serial offset bit per write clock edge
    task automatic shift(input bit b);
        @(negedge wclk);
        @(posedge mclk);
        offset_load_n <= 1'b0;
        serial_shift_enable_n <= 1'b0;
        fallthrough_sel_serial_in <= b;
        @(posedge wclk);
        repeat (5) @(posedge mclk);
        {offset_load_n, serial_shift_enable_n} <= 2'h3;
    endtask
    task automatic mreset(input bit ft, input bit ldpin);
        @(posedge mclk);
        master_reset_n <= 1'b0;
        fallthrough_sel_serial_in <= ft;
        offset_load_n <= ldpin;
        repeat (8) @(posedge mclk);
        master_reset_n <= 1'b1;
        offset_load_n <= 1'b1;
        repeat (8) @(posedge mclk);
    endtask
endmodule // dcf_pins_model

//--- dcf_fifo_flags_test.sv
// Self-checking bench of the FIFO flag block
module dcf_fifo_flags_test
    import dcf_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int D = 64;
    // Offset registers are only as wide as the address
    localparam int OW = $clog2(D);
    logic [2*OW-1:0] w;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic mr_n, sel, ld_n, sen_n, wclk, wen_n, rclk, ren_n;
    logic ff_n, ir_n, ef_n, or_n, af_n, ae_n, hf_n;
    logic [DATA_W-1:0] wd, rd, last_q;
    logic [DATA_W-1:0] q_exp[$];
    int bad_count = 0;
    int checks_done = 0;
    int seed = 88;
    int cnt, n, m;
    bit ft;
    always #10 mclk = ~mclk;
    dcf_pins_model dcf_pins_model_i (.mclk(mclk), .master_reset_n(mr_n),
        .fallthrough_sel_serial_in(sel), .offset_load_n(ld_n),
        .serial_shift_enable_n(sen_n), .wclk(wclk), .write_en_n(wen_n),
        .write_data_bus(wd), .rclk(rclk), .read_en_n(ren_n));
    dcf_fifo_flags #(.DEPTH(D)) dcf_fifo_flags_i (.mclk(mclk), .rst(rst),
        .master_reset_n(mr_n), .fallthrough_sel_serial_in(sel),
        .offset_load_n(ld_n), .wclk(wclk), .write_en_n(wen_n),
        .serial_shift_enable_n(sen_n), .write_data_bus(wd), .rclk(rclk),
        .read_en_n(ren_n), .read_data_bus(rd), .full_flag_n(ff_n),
        .input_ready_n(ir_n), .empty_flag_n(ef_n), .output_ready_n(or_n),
        .almost_full_n(af_n), .almost_empty_n(ae_n), .half_full_n(hf_n));
    //=========================================================
    // Compare tasks and expected flags from the word count
    task automatic cmp_data(input logic [DATA_W-1:0] e, g);
        checks_done++;
        if (g !== e) begin
            bad_count++;
            $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    task automatic cmp_flags(input logic [6:0] e, g);
        checks_done++;
        if (g !== e) begin
            bad_count++;
            $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    function automatic logic [6:0] fx(int k);
        if (ft) return {1'b1, k >= D + 1, 1'b1, k == 0, !(k >= D + 1 - m),
                        k >= n + 2, !(k >= D / 2 + 2)};
        return {!(k >= D), 1'b1, k != 0, 1'b1, !(k >= D - m), k >= n + 1,
                !(k >= D / 2 + 1)};
    endfunction
    // Three read edges plus syncs must fit inside the settle time
    task automatic settle_chk();
        repeat (60) @(posedge mclk);
        cmp_flags(fx(cnt), {ff_n, ir_n, ef_n, or_n, af_n, ae_n, hf_n});
    endtask
    //=========================================================
    // Watcher: each change of the output word takes one note
    always @(posedge mclk) begin
        last_q <= rd;
        if (rd !== last_q && q_exp.size() > 0)
            cmp_data(q_exp.pop_front(), rd);
    end
    task automatic run(input bit f);
        logic [DATA_W-1:0] d;
        ft = f;
        cnt = 0;
        dcf_pins_model_i.mreset(f, 1'b0);
        q_exp.push_back(DATA_W'(OFS_PARALLEL_DEF[OW-1:0]));
        dcf_pins_model_i.op(1'b1, 1'b1, '0);
        dcf_pins_model_i.op(1'b1, 1'b1, '0);
        n = 2 + {$random(seed)} % 4;
        m = n + 1 + {$random(seed)} % 3;
        dcf_pins_model_i.op(1'b0, 1'b1, DATA_W'(n));
        dcf_pins_model_i.op(1'b0, 1'b1, DATA_W'(m));
        q_exp.push_back(DATA_W'(n));
        q_exp.push_back(DATA_W'(m));
        dcf_pins_model_i.op(1'b1, 1'b1, '0);
        dcf_pins_model_i.op(1'b1, 1'b1, '0);
        for (int i = 0; i <= D + f; i++) begin
            d = DATA_W'({$random(seed)});
            d[5:0] = i[5:0];
            if (i < D + f) q_exp.push_back(d);
            if (i < D + f) cnt++;
            dcf_pins_model_i.op(1'b0, 1'b0, d);
            settle_chk();
        end
        repeat (D + f + 1) begin
            dcf_pins_model_i.op(1'b1, 1'b0, '0);
            if (cnt > 0) cnt--;
            settle_chk();
        end
        d = DATA_W'({$random(seed)});
        q_exp.push_back(d);
        dcf_pins_model_i.op(1'b0, 1'b0, d);
        cnt = 1;
        settle_chk();
        if (!f) dcf_pins_model_i.op(1'b1, 1'b0, '0);
        repeat (30) @(posedge mclk);
    endtask
    task automatic give_verdict();
        $display("checks %0d errors %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    //=========================================================
    // Main sequence and watchdog
    initial begin
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        run(1'b1);
        run(1'b0);
        dcf_pins_model_i.mreset(1'b0, 1'b1);
        q_exp.push_back(DATA_W'(OFS_SERIAL_DEF[OW-1:0]));
        dcf_pins_model_i.op(1'b1, 1'b1, '0);
        w = {6'h2A, 6'h15};
        for (int i = 0; i < 2 * OW; i++)
            dcf_pins_model_i.shift(w[i]);
        q_exp.push_back(DATA_W'(w[2*OW-1:OW]));
        q_exp.push_back(DATA_W'(w[OW-1:0]));
        dcf_pins_model_i.op(1'b1, 1'b1, '0);
        dcf_pins_model_i.op(1'b1, 1'b1, '0);
        repeat (20) @(posedge mclk);
        cmp_data('0, DATA_W'(q_exp.size()));
        give_verdict();
    end
    initial begin
        repeat (90000) @(posedge mclk);
        bad_count++;
        give_verdict();
    end
endmodule // dcf_fifo_flags_test
